/* File: rtl/link_tx_params.svh */
// Constants for the transmit user port
`ifndef LINK_TX_PARAMS_SVH
`define LINK_TX_PARAMS_SVH
`define LANE_WORD_W       64
`define SIDEBAND_W        8
`define ERR_W             4
`define ERR_BIT_OVERFLOW  0
`define ERR_BIT_GAP       3
`define RESET_SEQ_NS      64
`define CLK_PERIOD_NS     4
`define RESET_SEQ_CYCLES  ((`RESET_SEQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BURST_GAP_DEFAULT 4
`endif

/* File: rtl/link_tx_pkg.sv */
// Types for the transmit user port
package link_tx_pkg;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_WAIT  = 2'b01,
        ST_UP    = 2'b10
    } init_state_t;

    typedef enum logic [1:0] {
        BS_IDLE  = 2'b00,
        BS_BURST = 2'b01,
        BS_GAP   = 2'b10
    } burst_state_t;
endpackage

/* File: rtl/word_buf_if.sv */
// Handshake bundle for the two-entry word buffer
`timescale 1ns/1ps
`default_nettype none
interface word_buf_if #(parameter int W = 64);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport buf_side (input in_valid, in_data, out_ready,
                      output in_ready, out_valid, out_data);
    modport user_side (output in_valid, in_data, out_ready,
                       input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* File: rtl/word_buf.sv */
// Two-entry buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module word_buf #(
    parameter int W = 64
) (
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    word_buf_if.buf_side bus
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wr_ptr;
        logic              rd_ptr;
        logic [1:0]        count;
        logic [W-1:0]      dout;
        logic              dvalid;
    } buf_state_t;

    buf_state_t st_reg;
    buf_state_t st_next;
    logic       push;
    logic       pop;
    logic       load;

    assign bus.in_ready  = (st_reg.count != 2'h2);
    assign bus.out_valid = st_reg.dvalid;
    assign bus.out_data  = st_reg.dout;

    always_comb begin
        st_next = st_reg;
        push    = bus.in_valid && bus.in_ready;
        load    = (st_reg.count != 2'h0) && (!st_reg.dvalid || bus.out_ready);
        pop     = load;
        if (bus.out_ready && st_reg.dvalid) begin
            st_next.dvalid = 1'b0;
        end
        if (load) begin
            st_next.dout   = st_reg.mem[st_reg.rd_ptr];
            st_next.dvalid = 1'b1;
            st_next.rd_ptr = ~st_reg.rd_ptr;
        end
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = bus.in_data;
            st_next.wr_ptr             = ~st_reg.wr_ptr;
        end
        st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    initial begin
        if (W < 1) begin
            $error("word_buf width must be positive");
        end
    end

    count_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_reg.count <= 2'h2)
        else $error("Buffer count above two");
endmodule
`default_nettype wire

/* File: rtl/link_tx_port.sv */
// Transmit user port: clocking, resets, link-ready and burst framing
`timescale 1ns/1ps
`default_nettype none
`include "link_tx_params.svh"

// Functional notes
// - Serial clock vector, one bit per lane
// - Master reset async high; PLL excluded
// - Tx clock input advanced, output standard
// - Standard: tx reset high until sequence done
// - Advanced only: core-domain interface reset output
// - Link-ready only after init complete
// - Payload is 64 bits per lane
// - Sideband sampled at burst first, last
// - Sideband carried without interpretation
// - Gap mismatch flagged on error bit 3
module link_tx_port
    import link_tx_pkg::*;
#(
    parameter int LANES        = 1,
    parameter bit ADVANCED_CLK = 1'b0,
    parameter int BURST_GAP    = `BURST_GAP_DEFAULT
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    input  wire logic [LANES-1:0]              tx_serial_clk,
    input  wire logic                          tx_pll_locked,
    input  wire logic                          core_reset,
    input  wire logic                          user_clock_tx_in,
    output logic                               user_clock_tx_out,
    output logic                               user_clock_tx_oe_n,
    input  wire logic                          user_clock_reset_tx_in,
    output logic                               user_clock_reset_tx_out,
    output logic                               user_clock_reset_tx_oe_n,
    output logic                               interface_clock_reset_tx,
    output logic                               link_up_tx,
    input  wire logic [LANES*`LANE_WORD_W-1:0] data_tx,
    input  wire logic [`SIDEBAND_W-1:0]        sync_tx,
    input  wire logic                          valid_tx,
    input  wire logic                          tx_burst_first,
    input  wire logic                          tx_burst_last,
    output logic                               tx_ready,
    output logic [`ERR_W-1:0]                  error_tx,
    output logic [LANES*`LANE_WORD_W-1:0]      link_data,
    output logic [`SIDEBAND_W-1:0]             link_side_first,
    output logic [`SIDEBAND_W-1:0]             link_side_last,
    output logic                               link_first,
    output logic                               link_last,
    output logic                               link_valid,
    input  wire logic                          link_ready,
    output logic [LANES-1:0]                   lane_clk_seen
);
    localparam int DW   = LANES * `LANE_WORD_W;
    localparam int PW   = DW + 2 * `SIDEBAND_W + 2;
    localparam int RSEQ = `RESET_SEQ_CYCLES;

    typedef struct packed {
        init_state_t  init;
        logic [7:0]   seq_cnt;
        burst_state_t bst;
        logic [15:0]  gap_cnt;
        logic [`SIDEBAND_W-1:0] side_first;
        logic [`ERR_W-1:0]      err;
        logic         clk_div;
    } port_state_t;

    port_state_t st_reg;
    port_state_t st_next;
    logic        mac_rst;
    logic        fifo_clr;
    logic        take;
    logic        gap_bad;

    word_buf_if #(.W(PW)) wb ();

    // Master reset clears the path; user reset clears it in advanced clocking only
    assign mac_rst  = core_reset || !rst_n;
    assign fifo_clr = ADVANCED_CLK && user_clock_reset_tx_in;

    function automatic logic gap_mismatch(input logic [15:0] cnt);
        return cnt != 16'(BURST_GAP);
    endfunction

    // Per-lane serial clock activity, one flop per lane
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge tx_serial_clk[g] or posedge mac_rst) begin
                if (mac_rst) begin
                    lane_clk_seen[g] <= 1'b0;
                end else begin
                    lane_clk_seen[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // Accept only when link is up and buffer has room
    assign tx_ready = (st_reg.init == ST_UP) && wb.in_ready && !fifo_clr;
    assign take     = valid_tx && tx_ready;
    assign gap_bad  = take && tx_burst_first && (st_reg.bst == BS_GAP)
                      && gap_mismatch(st_reg.gap_cnt);

    always_comb begin
        st_next = st_reg;
        st_next.clk_div = ~st_reg.clk_div;
        case (st_reg.init)
            ST_RESET: begin
                st_next.seq_cnt = '0;
                st_next.init    = ST_WAIT;
            end
            ST_WAIT: begin
                if (tx_pll_locked) begin
                    if (st_reg.seq_cnt == 8'(RSEQ - 1)) begin
                        st_next.init = ST_UP;
                    end else begin
                        st_next.seq_cnt = st_reg.seq_cnt + 8'h01;
                    end
                end else begin
                    st_next.seq_cnt = '0;
                end
            end
            ST_UP: begin
                if (!tx_pll_locked) begin
                    st_next.init = ST_RESET;
                end
            end
            default: begin
                st_next.init = ST_RESET;
            end
        endcase
        case (st_reg.bst)
            BS_IDLE: begin
                if (take && tx_burst_first && !tx_burst_last) begin
                    st_next.bst = BS_BURST;
                end else if (take && tx_burst_last) begin
                    st_next.bst     = BS_GAP;
                    st_next.gap_cnt = '0;
                end
            end
            BS_BURST: begin
                if (take && tx_burst_last) begin
                    st_next.bst     = BS_GAP;
                    st_next.gap_cnt = '0;
                end
            end
            BS_GAP: begin
                if (take && tx_burst_first) begin
                    st_next.bst = tx_burst_last ? BS_GAP : BS_BURST;
                    st_next.gap_cnt = '0;
                end else if (st_reg.gap_cnt != 16'hffff) begin
                    st_next.gap_cnt = st_reg.gap_cnt + 16'h0001;
                end
            end
            default: begin
                st_next.bst = BS_IDLE;
            end
        endcase
        if (take && tx_burst_first) begin
            st_next.side_first = sync_tx;
        end
        if (gap_bad) begin
            st_next.err[`ERR_BIT_GAP] = 1'b1;
        end
        if (valid_tx && !tx_ready && st_reg.init == ST_UP && !fifo_clr) begin
            st_next.err[`ERR_BIT_OVERFLOW] = 1'b1;
        end
        if (fifo_clr) begin
            st_next.err = '0;
            st_next.bst = BS_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge mac_rst) begin
        if (mac_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Sideband stored untouched next to the payload
    assign wb.in_valid  = take;
    assign wb.in_data   = {data_tx,
                           (tx_burst_first ? sync_tx : st_reg.side_first),
                           sync_tx, tx_burst_first, tx_burst_last};
    assign wb.out_ready = link_ready;

    word_buf #(.W(PW)) u_buf (
        .clk_sys (clk_sys),
        .rst_n   (rst_n && !core_reset && !fifo_clr),
        .bus     (wb)
    );

    assign link_valid      = wb.out_valid;
    assign link_data       = wb.out_data[PW-1 -: DW];
    assign link_side_first = wb.out_data[2*`SIDEBAND_W+1 -: `SIDEBAND_W];
    assign link_side_last  = link_last ? wb.out_data[`SIDEBAND_W+1 -: `SIDEBAND_W]
                                       : '0;
    assign link_first      = wb.out_data[1];
    assign link_last       = wb.out_data[0];

    // Clock and reset pins by clocking mode
    assign user_clock_tx_out        = ADVANCED_CLK ? 1'b0 : st_reg.clk_div;
    assign user_clock_tx_oe_n       = ADVANCED_CLK;
    assign user_clock_reset_tx_out  = !ADVANCED_CLK && (st_reg.init != ST_UP);
    assign user_clock_reset_tx_oe_n = ADVANCED_CLK;
    assign interface_clock_reset_tx = ADVANCED_CLK && (st_reg.init != ST_UP);
    assign link_up_tx               = (st_reg.init == ST_UP);
    assign error_tx                 = st_reg.err;

    initial begin
        if (LANES < 1 || LANES > 24) begin
            $error("LANES out of range");
        end
        if (BURST_GAP < 0 || BURST_GAP > 65535) begin
            $error("BURST_GAP out of range");
        end
        if (RSEQ < 1 || RSEQ > 256) begin
            $error("Reset sequence count out of range");
        end
    end

    sequence seq_lock_hold;
        tx_pll_locked [*8];
    endsequence

    link_ready_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        link_up_tx |-> $past(tx_pll_locked))
        else $error("Link up without lock");
    tx_reset_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        !ADVANCED_CLK |-> (user_clock_reset_tx_out == !link_up_tx))
        else $error("Tx reset not tied to init");
    if_reset_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        ADVANCED_CLK || !interface_clock_reset_tx)
        else $error("Interface reset in standard mode");
    up_after_seq_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        $rose(link_up_tx) |-> $past(tx_pll_locked, 2))
        else $error("Link up too soon");
    gap_err_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        gap_bad && !fifo_clr |=> error_tx[`ERR_BIT_GAP])
        else $error("Gap error not flagged");
    side_first_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        take && tx_burst_first |=> st_reg.side_first == $past(sync_tx))
        else $error("First sideband not captured");
    clk_dir_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        user_clock_tx_oe_n == ADVANCED_CLK)
        else $error("Clock pin direction wrong");
    locked_up_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        seq_lock_hold ##1 tx_pll_locked [*8] |-> ##[0:20] link_up_tx || !tx_pll_locked)
        else $error("Link not up after lock");
    no_take_down_a: assert property (@(posedge clk_sys) disable iff (mac_rst)
        !link_up_tx |-> !take)
        else $error("Data taken while link down");
endmodule
`default_nettype wire

/* File: sim/user_src_model.sv */
// Behavioural user source that feeds bursts into the transmit port
`timescale 1ns/1ps
`default_nettype none
`include "link_tx_params.svh"
module user_src_model #(
    parameter int W = 64
) (
    input  wire logic                   clk_sys,
    input  wire logic                   tx_ready,
    input  wire logic                   run,
    input  wire logic                   pushy,
    input  var  int                     gap,
    output logic     [W-1:0]            data_tx,
    output logic     [`SIDEBAND_W-1:0]  sync_tx,
    output logic                        valid_tx,
    output logic                        tx_burst_first,
    output logic                        tx_burst_last
);
    int   len;
    logic ok;
    initial begin
        data_tx = '0;
        sync_tx = 8'h0;
        valid_tx = 1'b0;
        tx_burst_first = 1'b0;
        tx_burst_last = 1'b0;
        forever begin
            @(negedge clk_sys);
            if (run) begin
                len = $urandom_range(4, 1);
                for (int i = 0; i < len; i++) begin
                    // Waits for ready with valid low unless told to push into a full buffer
                    while (!tx_ready && !pushy) begin
                        valid_tx = 1'b0;
                        tx_burst_first = 1'b0;
                        tx_burst_last = 1'b0;
                        @(negedge clk_sys);
                    end
                    data_tx = {$urandom, $urandom};
                    sync_tx = (i == len - 1) ? 8'h0 : 8'($urandom);
                    valid_tx = 1'b1;
                    tx_burst_first = (i == 0);
                    tx_burst_last = (i == len - 1);
                    // Ready moves only on a rising edge, so this value holds at the next one
                    ok = tx_ready;
                    @(negedge clk_sys);
                    while (!ok) begin
                        ok = tx_ready;
                        @(negedge clk_sys);
                    end
                end
                valid_tx = 1'b0;
                tx_burst_first = 1'b0;
                tx_burst_last = 1'b0;
                data_tx = ~data_tx;
                sync_tx = ~sync_tx;
                // Idle cycles between last and next first
                repeat (gap - 1) @(negedge clk_sys);
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the transmit user port
`timescale 1ns/1ps
`default_nettype none
`include "link_tx_params.svh"
module testbench
    import link_tx_pkg::*;
;
    localparam int GAP = `BURST_GAP_DEFAULT;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        core_reset = 1'b0;
    logic        tx_pll_locked = 1'b0;
    logic [0:0]  tx_serial_clk = 1'b0;
    logic        sclk_on = 1'b0;
    logic        link_ready = 1'b1;
    logic        stall = 1'b0;
    logic        hold_sink = 1'b0;
    logic        run = 1'b0;
    logic        pushy = 1'b0;
    int          gap = GAP;
    logic [63:0] data_tx;
    logic [7:0]  sync_tx, link_side_first, link_side_last, cur_sf;
    logic        valid_tx, tx_burst_first, tx_burst_last, tx_ready;
    logic        ck_out, ck_oe_n, rst_out, rst_oe_n, if_rst, link_up_tx;
    logic        link_first, link_last, link_valid;
    logic [3:0]  error_tx;
    logic [63:0] link_data;
    logic [0:0]  lane_clk_seen;
    logic [81:0] q[$];
    logic [81:0] got;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic        a;
    logic        av = 1'b0;
    logic        ar = 1'b0;
    logic        ck_out_a, ck_oe_a, rst_out_a, rst_oe_a, if_rst_a, up_a, ready_a, lv_a;
    logic [3:0]  err_a;

    link_tx_port #(.LANES(1), .ADVANCED_CLK(1'b0), .BURST_GAP(GAP)) i_link_tx_port (
        .clk_sys(clk_sys), .rst_n(rst_n), .tx_serial_clk(tx_serial_clk),
        .tx_pll_locked(tx_pll_locked), .core_reset(core_reset), .user_clock_tx_in(1'b0),
        .user_clock_tx_out(ck_out), .user_clock_tx_oe_n(ck_oe_n),
        .user_clock_reset_tx_in(1'b0), .user_clock_reset_tx_out(rst_out),
        .user_clock_reset_tx_oe_n(rst_oe_n), .interface_clock_reset_tx(if_rst),
        .link_up_tx(link_up_tx), .data_tx(data_tx), .sync_tx(sync_tx), .valid_tx(valid_tx),
        .tx_burst_first(tx_burst_first), .tx_burst_last(tx_burst_last), .tx_ready(tx_ready),
        .error_tx(error_tx), .link_data(link_data), .link_side_first(link_side_first),
        .link_side_last(link_side_last), .link_first(link_first), .link_last(link_last),
        .link_valid(link_valid), .link_ready(link_ready), .lane_clk_seen(lane_clk_seen));

    user_src_model #(.W(64)) i_user_src_model (
        .clk_sys(clk_sys), .tx_ready(tx_ready), .run(run), .pushy(pushy), .gap(gap),
        .data_tx(data_tx), .sync_tx(sync_tx), .valid_tx(valid_tx),
        .tx_burst_first(tx_burst_first), .tx_burst_last(tx_burst_last));

    // Second port in advanced clocking, own valid and adaptation reset
    if (1) begin : g_adv
        link_tx_port #(.LANES(1), .ADVANCED_CLK(1'b1), .BURST_GAP(GAP)) i_link_tx_port (
            .clk_sys(clk_sys), .rst_n(rst_n), .tx_serial_clk(tx_serial_clk),
            .tx_pll_locked(tx_pll_locked), .core_reset(core_reset), .user_clock_tx_in(clk_sys),
            .user_clock_tx_out(ck_out_a), .user_clock_tx_oe_n(ck_oe_a),
            .user_clock_reset_tx_in(ar), .user_clock_reset_tx_out(rst_out_a),
            .user_clock_reset_tx_oe_n(rst_oe_a), .interface_clock_reset_tx(if_rst_a),
            .link_up_tx(up_a), .data_tx(data_tx), .sync_tx(sync_tx), .valid_tx(av),
            .tx_burst_first(tx_burst_first), .tx_burst_last(tx_burst_last), .tx_ready(ready_a),
            .error_tx(err_a), .link_data(), .link_side_first(), .link_side_last(),
            .link_first(), .link_last(), .link_valid(lv_a), .link_ready(link_ready),
            .lane_clk_seen());
    end

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    always #3.3 if (sclk_on) tx_serial_clk = ~tx_serial_clk;
    always @(negedge clk_sys) link_ready <= hold_sink ? 1'b0 : (stall ? 1'($urandom) : 1'b1);

    function automatic logic [81:0] exp_word(logic [63:0] d, logic [7:0] sf, logic [7:0] s,
                                             logic f, logic l);
        return {d, f ? s : sf, l ? s : 8'h0, f, l};
    endfunction

    task automatic check(input logic [81:0] seen, input logic [81:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wait_up();
        int k;
        for (k = 0; k < 40 && link_up_tx !== 1'b1; k++) @(negedge clk_sys);
        check(82'(link_up_tx), 82'h1);
    endtask

    task automatic pulse_reset();
        core_reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(82'({link_up_tx, rst_out, error_tx}), 82'h10);
        core_reset = 1'b0;
        wait_up();
    endtask

    task automatic traffic(input int n);
        run = 1'b1;
        repeat (n) @(negedge clk_sys);
        run = 1'b0;
        repeat (30) @(negedge clk_sys);
    endtask

    // Cycle watchdog, then input-side record and output-side compare
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    always @(posedge clk_sys) begin
        if (valid_tx && tx_ready) begin
            q.push_back(exp_word(data_tx, cur_sf, sync_tx, tx_burst_first, tx_burst_last));
            if (tx_burst_first) cur_sf = sync_tx;
        end
        if (link_valid === 1'b1 && link_ready) begin
            got = {link_data, link_side_first, link_side_last, link_first, link_last};
            if (q.size() == 0) check(got, 82'h0);
            else check(got, q.pop_front());
        end
    end

    initial begin
        void'($urandom(32'h7bcfd92d));
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check(82'(rst_out), 82'h1);
        check(82'({ck_oe_n, rst_oe_n}), 82'h0);
        check(82'({ck_oe_a, rst_oe_a, ck_out_a}), 82'h6);
        check(82'({if_rst, if_rst_a, rst_out_a}), 82'h2);
        check(82'(lane_clk_seen), 82'h0);
        sclk_on = 1'b1;
        repeat (20) @(negedge clk_sys);
        check(82'(link_up_tx), 82'h0);
        tx_pll_locked = 1'b1;
        repeat (`RESET_SEQ_CYCLES - 1) @(negedge clk_sys);
        check(82'({link_up_tx, up_a}), 82'h0);
        @(negedge clk_sys);
        check(82'({link_up_tx, up_a}), 82'h3);
        check(82'(rst_out), 82'h0);
        check(82'({if_rst, if_rst_a}), 82'h0);
        check(82'(lane_clk_seen), 82'h1);
        a = ck_out;
        @(negedge clk_sys);
        check(82'(ck_out), 82'(!a));
        traffic(300);
        check(82'(error_tx), 82'h0);
        pulse_reset();
        gap = GAP - 1;
        traffic(60);
        check(82'(error_tx[`ERR_BIT_GAP]), 82'h1);
        gap = GAP;
        pulse_reset();
        stall = 1'b1;
        traffic(400);
        stall = 1'b0;
        check(82'(error_tx[`ERR_BIT_OVERFLOW]), 82'h0);
        hold_sink = 1'b1;
        pushy = 1'b1;
        run = 1'b1;
        av = 1'b1;
        repeat (30) @(negedge clk_sys);
        check(82'(tx_ready), 82'h0);
        check(82'(error_tx[`ERR_BIT_OVERFLOW]), 82'h1);
        check(82'({ready_a, err_a[`ERR_BIT_OVERFLOW]}), 82'h1);
        ar = 1'b1;
        @(negedge clk_sys);
        check(82'({ready_a, err_a, lv_a}), 82'h0);
        av = 1'b0;
        ar = 1'b0;
        @(negedge clk_sys);
        check(82'(ready_a), 82'h1);
        run = 1'b0;
        pushy = 1'b0;
        hold_sink = 1'b0;
        repeat (40) @(negedge clk_sys);
        check(82'(q.size()), 82'h0);
        tx_pll_locked = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(82'(link_up_tx), 82'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
